// ==== design/ptev_defs.svh ====
`ifndef PTEV_DEFS_SVH
`define PTEV_DEFS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define PTEV_NCH 8
`define PTEV_NPIN 32
`define PTEV_NIC 16
`define PTEV_NTASK 3

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PTEV_OFF_OUT_TRIG 12'h000
`define PTEV_OFF_SET_TRIG 12'h030
`define PTEV_OFF_CLR_TRIG 12'h060
`define PTEV_OFF_SUB_OUT 12'h080
`define PTEV_OFF_SUB_SET 12'h0b0
`define PTEV_OFF_SUB_CLR 12'h0e0
`define PTEV_OFF_EVT_FLAG 12'h100
`define PTEV_OFF_PORT_FLAG 12'h17c
`define PTEV_OFF_PUB_EVT 12'h180
`define PTEV_OFF_PUB_PORT 12'h1fc
`define PTEV_OFF_IRQ_ON 12'h304
`define PTEV_OFF_IRQ_OFF 12'h308
`define PTEV_OFF_CFG 12'h510
// last byte offset of an eight-word array relative to its base
`define PTEV_ARR_LAST 12'h01c

// ----------------------------------------
// field positions
// ----------------------------------------
`define PTEV_CFG_MODE 1:0
`define PTEV_CFG_PSEL 12:8
`define PTEV_CFG_POL 17:16
`define PTEV_CFG_INIT 20
`define PTEV_IC_IDX 3:0
`define PTEV_IC_EN 31
`define PTEV_TRIG_BIT 0
`define PTEV_PORT_BIT 8

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define PTEV_MODE_OFF_C 2'h0
`define PTEV_MODE_EVT_C 2'h1
`define PTEV_MODE_TASK_C 2'h3
`define PTEV_POL_NONE_C 2'h0
`define PTEV_POL_RISE_C 2'h1
`define PTEV_POL_FALL_C 2'h2
`define PTEV_POL_TOGL_C 2'h3
`define PTEV_RST_WORD 32'h0000_0000

`endif

// ==== design/ptev_pkg.sv ====
`include "ptev_defs.svh"

package ptev_pkg;
  // channel mode field
  typedef enum logic [1:0]
  {
    PTEV_MODE_OFF = `PTEV_MODE_OFF_C,
    PTEV_MODE_EVT = `PTEV_MODE_EVT_C,
    PTEV_MODE_TASK = `PTEV_MODE_TASK_C
  } ptev_mode_t;

  // polarity: none, rising_edge/set, falling_edge/clear, toggle/any change
  typedef enum logic [1:0]
  {
    PTEV_POL_NONE = `PTEV_POL_NONE_C,
    PTEV_POL_RISE = `PTEV_POL_RISE_C,
    PTEV_POL_FALL = `PTEV_POL_FALL_C,
    PTEV_POL_TOGL = `PTEV_POL_TOGL_C
  } ptev_pol_t;

  // task kinds, index into the subscription arrays
  typedef enum logic [1:0]
  {
    PTEV_TASK_OUT = 2'h0,
    PTEV_TASK_SET = 2'h1,
    PTEV_TASK_CLR = 2'h2
  } ptev_task_t;
endpackage

// ==== design/ptev_top.sv ====
// Operation
// - action trigger write one applies polarity action
// - drive-high trigger forces selected pin high
// - drive-low trigger forces selected pin low
// - enabled task subscription triggers on interconnect event
// - configured pin activity sets channel event flag
// - sense detection sets multi-pin event flag
// - enabled publish puts channel event on interconnect
// - multi-pin event publishes to selected interconnect channel
// - irq_enable_on write one enables event interrupt
// - irq_enable_off write one disables event interrupt
// - both enable registers read current enable state
// - disabled channel leaves pin to ordinary GPIO
// - event mode makes pin input, detects polarity
// - task mode makes pin output, tasks drive
// - task mode blocks ordinary GPIO output writes
// - pin-select field picks one of 32 pins
// - polarity codes none, rise/set, fall/clear, toggle
// - task mode initial output level on configure
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "ptev_defs.svh"

module ptev_top
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [`PTEV_NIC-1:0] ic_evt_i,
  output logic [`PTEV_NIC-1:0] ic_pub_o,
  input wire logic [`PTEV_NPIN-1:0] pin_in_i,
  input wire logic [`PTEV_NPIN-1:0] gpio_out_i,
  input wire logic [`PTEV_NPIN-1:0] gpio_oe_i,
  output logic [`PTEV_NPIN-1:0] pin_out_o,
  output logic [`PTEV_NPIN-1:0] pin_oe_o,
  input wire logic sense_detect_i,
  output logic irq_o
);
  import ptev_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // word hit inside an eight-word array
  function automatic logic in_arr(input logic [11:0] a, input logic [11:0] base);
    in_arr = (a >= base) && (a <= base + `PTEV_ARR_LAST) && (a[1:0] == 2'h0);
  endfunction

  // channel index of a word inside an array
  function automatic logic [2:0] arr_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    arr_idx = d[4:2];
  endfunction

  // pack a publish or subscribe word
  function automatic logic [31:0] ic_word(input logic en, input logic [3:0] idx);
    logic [31:0] w;
    w = `PTEV_RST_WORD;
    w[`PTEV_IC_IDX] = idx;
    w[`PTEV_IC_EN] = en;
    ic_word = w;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  ptev_mode_t mode_r [`PTEV_NCH]; // channel mode
  logic [4:0] psel_r [`PTEV_NCH]; // selected pin
  ptev_pol_t pol_r [`PTEV_NCH]; // action or edge
  logic init_r [`PTEV_NCH]; // initial output level
  logic [3:0] sub_idx_r [`PTEV_NTASK][`PTEV_NCH]; // subscribed channel
  logic sub_en_r [`PTEV_NTASK][`PTEV_NCH]; // subscription enable
  logic [3:0] pub_idx_r [`PTEV_NCH]; // publish channel per event
  logic pub_en_r [`PTEV_NCH]; // publish enable per event
  logic [3:0] port_idx_r; // multi-pin publish channel
  logic port_en_r; // multi-pin publish enable
  logic [`PTEV_NCH-1:0] ch_out_r; // task-driven level
  logic [`PTEV_NCH-1:0] prev_r; // last sampled pin level
  logic [`PTEV_NCH-1:0] flag_r; // channel event flags
  logic port_flag_r; // multi-pin event flag
  logic [8:0] inten_r; // interrupt enables, bit 8 multi-pin
  logic [`PTEV_NIC-1:0] pub_r; // interconnect publish pulses
  logic [`PTEV_NIC-1:0] pub_nxt;
  logic [31:0] rdata_r; // read data, one cycle after strobe
  logic irq_r; // registered interrupt line

  // ----------------------------------------
  // write decode and triggers
  // ----------------------------------------
  logic [`PTEV_NCH-1:0] trig_out; // action task fires
  logic [`PTEV_NCH-1:0] trig_set; // drive-high task fires
  logic [`PTEV_NCH-1:0] trig_clr; // drive-low task fires
  logic [`PTEV_NCH-1:0] cfg_wr; // channel setup written
  logic [`PTEV_NCH-1:0] flag_wr; // event flag written
  logic [`PTEV_NCH-1:0] pin_now; // selected pin level
  logic [`PTEV_NCH-1:0] evt_hit; // configured activity seen
  logic [11:0] task_base [`PTEV_NTASK];
  logic [11:0] sub_base [`PTEV_NTASK];
  logic [2:0] task_fire [`PTEV_NCH];

  assign task_base[0] = `PTEV_OFF_OUT_TRIG;
  assign task_base[1] = `PTEV_OFF_SET_TRIG;
  assign task_base[2] = `PTEV_OFF_CLR_TRIG;
  assign sub_base[0] = `PTEV_OFF_SUB_OUT;
  assign sub_base[1] = `PTEV_OFF_SUB_SET;
  assign sub_base[2] = `PTEV_OFF_SUB_CLR;

  // a task fires from a register write of one or an interconnect event
  always_comb
  begin
    for (int c = 0; c < `PTEV_NCH; c++)
    begin
      for (int t = 0; t < `PTEV_NTASK; t++)
      begin
        task_fire[c][t] = (wr_i && in_arr(addr_i, task_base[t]) && arr_idx(addr_i, task_base[t]) == 3'(c)
                           && wdata_i[`PTEV_TRIG_BIT])
                          || (sub_en_r[t][c] && ic_evt_i[sub_idx_r[t][c]]);
      end
      // tasks only reach a pin the channel owns as output
      trig_out[c] = task_fire[c][0] && (mode_r[c] == PTEV_MODE_TASK);
      trig_set[c] = task_fire[c][1] && (mode_r[c] == PTEV_MODE_TASK);
      trig_clr[c] = task_fire[c][2] && (mode_r[c] == PTEV_MODE_TASK);
      cfg_wr[c] = wr_i && in_arr(addr_i, `PTEV_OFF_CFG) && arr_idx(addr_i, `PTEV_OFF_CFG) == 3'(c);
      flag_wr[c] = wr_i && in_arr(addr_i, `PTEV_OFF_EVT_FLAG) && arr_idx(addr_i, `PTEV_OFF_EVT_FLAG) == 3'(c);
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // channel setup, subscriptions and publications
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      for (int c = 0; c < `PTEV_NCH; c++)
      begin
        mode_r[c] <= PTEV_MODE_OFF;
        psel_r[c] <= 5'h00;
        pol_r[c] <= PTEV_POL_NONE;
        init_r[c] <= 1'b0;
        pub_idx_r[c] <= 4'h0;
        pub_en_r[c] <= 1'b0;
        for (int t = 0; t < `PTEV_NTASK; t++)
        begin
          sub_idx_r[t][c] <= 4'h0;
          sub_en_r[t][c] <= 1'b0;
        end
      end
      port_idx_r <= 4'h0;
      port_en_r <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < `PTEV_NCH; c++)
      begin
        // setup word carries mode, pin, polarity, initial level
        if (cfg_wr[c])
        begin
          mode_r[c] <= ptev_mode_t'(wdata_i[`PTEV_CFG_MODE]);
          psel_r[c] <= wdata_i[`PTEV_CFG_PSEL];
          pol_r[c] <= ptev_pol_t'(wdata_i[`PTEV_CFG_POL]);
          init_r[c] <= wdata_i[`PTEV_CFG_INIT];
        end
        if (wr_i && in_arr(addr_i, `PTEV_OFF_PUB_EVT) && arr_idx(addr_i, `PTEV_OFF_PUB_EVT) == 3'(c))
        begin
          pub_idx_r[c] <= wdata_i[`PTEV_IC_IDX];
          pub_en_r[c] <= wdata_i[`PTEV_IC_EN];
        end
        for (int t = 0; t < `PTEV_NTASK; t++)
        begin
          if (wr_i && in_arr(addr_i, sub_base[t]) && arr_idx(addr_i, sub_base[t]) == 3'(c))
          begin
            sub_idx_r[t][c] <= wdata_i[`PTEV_IC_IDX];
            sub_en_r[t][c] <= wdata_i[`PTEV_IC_EN];
          end
        end
      end
      if (wr_i && addr_i == `PTEV_OFF_PUB_PORT)
      begin
        port_idx_r <= wdata_i[`PTEV_IC_IDX];
        port_en_r <= wdata_i[`PTEV_IC_EN];
      end
    end
  end

  // ----------------------------------------
  // task output level
  // ----------------------------------------
  // setup load first, then tasks; clear beats set beats action
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      ch_out_r <= '0;
    else
    begin
      for (int c = 0; c < `PTEV_NCH; c++)
      begin
        if (cfg_wr[c])
          ch_out_r[c] <= wdata_i[`PTEV_CFG_INIT];
        if (trig_clr[c])
          ch_out_r[c] <= 1'b0;
        else if (trig_set[c])
          ch_out_r[c] <= 1'b1;
        else if (trig_out[c])
        begin
          case (pol_r[c])
            PTEV_POL_RISE: ch_out_r[c] <= 1'b1;
            PTEV_POL_FALL: ch_out_r[c] <= 1'b0;
            PTEV_POL_TOGL: ch_out_r[c] <= ~ch_out_r[c];
            default: ch_out_r[c] <= ch_out_r[c];
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // pin ownership
  // ----------------------------------------
  // later channels win if software maps one pin twice
  always_comb
  begin
    pin_out_o = gpio_out_i;
    pin_oe_o = gpio_oe_i;
    for (int c = 0; c < `PTEV_NCH; c++)
    begin
      if (mode_r[c] == PTEV_MODE_TASK)
      begin
        pin_out_o[psel_r[c]] = ch_out_r[c];
        pin_oe_o[psel_r[c]] = 1'b1;
      end
      else if (mode_r[c] == PTEV_MODE_EVT)
        pin_oe_o[psel_r[c]] = 1'b0;
    end
  end

  // ----------------------------------------
  // event detection and flags
  // ----------------------------------------
  // changing pin select may show one false edge
  always_comb
  begin
    for (int c = 0; c < `PTEV_NCH; c++)
    begin
      pin_now[c] = pin_in_i[psel_r[c]];
      case (pol_r[c])
        PTEV_POL_RISE: evt_hit[c] = pin_now[c] && !prev_r[c];
        PTEV_POL_FALL: evt_hit[c] = !pin_now[c] && prev_r[c];
        PTEV_POL_TOGL: evt_hit[c] = pin_now[c] ^ prev_r[c];
        default: evt_hit[c] = 1'b0;
      endcase
      evt_hit[c] = evt_hit[c] && (mode_r[c] == PTEV_MODE_EVT);
    end
  end

  // previous pin level per channel
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      prev_r <= '0;
    else
      prev_r <= pin_now;
  end

  // sticky flags; a hit in the clearing cycle still sets
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      flag_r <= '0;
      port_flag_r <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < `PTEV_NCH; c++)
        flag_r[c] <= evt_hit[c] | (flag_wr[c] ? wdata_i[`PTEV_TRIG_BIT] : flag_r[c]);
      if (wr_i && addr_i == `PTEV_OFF_PORT_FLAG)
        port_flag_r <= sense_detect_i | wdata_i[`PTEV_TRIG_BIT];
      else
        port_flag_r <= sense_detect_i | port_flag_r;
    end
  end

  // ----------------------------------------
  // publication
  // ----------------------------------------
  // several events on one channel merge into a single pulse
  always_comb
  begin
    pub_nxt = '0;
    for (int c = 0; c < `PTEV_NCH; c++)
      if (evt_hit[c] && pub_en_r[c])
        pub_nxt[pub_idx_r[c]] = 1'b1;
    if (sense_detect_i && port_en_r)
      pub_nxt[port_idx_r] = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      pub_r <= '0;
    else
      pub_r <= pub_nxt;
  end

  // ----------------------------------------
  // interrupt enables and line
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      inten_r <= '0;
    else if (wr_i && addr_i == `PTEV_OFF_IRQ_ON)
      inten_r <= inten_r | wdata_i[8:0];
    else if (wr_i && addr_i == `PTEV_OFF_IRQ_OFF)
      inten_r <= inten_r & ~wdata_i[8:0];
  end

  // registered to keep the line glitch free, one cycle behind flags
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      irq_r <= 1'b0;
    else
      irq_r <= |({port_flag_r, flag_r} & inten_r);
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // trigger words and unmapped addresses read zero
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      rdata_r <= `PTEV_RST_WORD;
    else
    begin
      rdata_r <= `PTEV_RST_WORD;
      if (rd_i)
      begin
        for (int t = 0; t < `PTEV_NTASK; t++)
          if (in_arr(addr_i, sub_base[t]))
            rdata_r <= ic_word(sub_en_r[t][arr_idx(addr_i, sub_base[t])], sub_idx_r[t][arr_idx(addr_i, sub_base[t])]);
        if (in_arr(addr_i, `PTEV_OFF_EVT_FLAG))
          rdata_r[`PTEV_TRIG_BIT] <= flag_r[arr_idx(addr_i, `PTEV_OFF_EVT_FLAG)];
        if (in_arr(addr_i, `PTEV_OFF_PUB_EVT))
          rdata_r <= ic_word(pub_en_r[arr_idx(addr_i, `PTEV_OFF_PUB_EVT)], pub_idx_r[arr_idx(addr_i, `PTEV_OFF_PUB_EVT)]);
        if (in_arr(addr_i, `PTEV_OFF_CFG))
        begin
          rdata_r[`PTEV_CFG_MODE] <= mode_r[arr_idx(addr_i, `PTEV_OFF_CFG)];
          rdata_r[`PTEV_CFG_PSEL] <= psel_r[arr_idx(addr_i, `PTEV_OFF_CFG)];
          rdata_r[`PTEV_CFG_POL] <= pol_r[arr_idx(addr_i, `PTEV_OFF_CFG)];
          rdata_r[`PTEV_CFG_INIT] <= init_r[arr_idx(addr_i, `PTEV_OFF_CFG)];
        end
        if (addr_i == `PTEV_OFF_PORT_FLAG)
          rdata_r[`PTEV_TRIG_BIT] <= port_flag_r;
        if (addr_i == `PTEV_OFF_PUB_PORT)
          rdata_r <= ic_word(port_en_r, port_idx_r);
        if (addr_i == `PTEV_OFF_IRQ_ON || addr_i == `PTEV_OFF_IRQ_OFF)
          rdata_r[8:0] <= inten_r;
      end
    end
  end

  assign rdata_o = rdata_r;
  assign ic_pub_o = pub_r;
  assign irq_o = irq_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_rd_enable;
    rd_i && (addr_i == `PTEV_OFF_IRQ_ON || addr_i == `PTEV_OFF_IRQ_OFF);
  endsequence

  sequence s_irq_pending;
    |({port_flag_r, flag_r} & inten_r);
  endsequence

  a_enable_read: assert property (s_rd_enable |=> rdata_o[8:0] == $past(inten_r) && rdata_o[31:9] == 23'h0)
    else $error("enable read mismatch");
  a_enable_set: assert property (wr_i && addr_i == `PTEV_OFF_IRQ_ON && wdata_i[8] |=> inten_r[8])
    else $error("enable set lost");
  a_enable_clear: assert property (wr_i && addr_i == `PTEV_OFF_IRQ_OFF && wdata_i[0] |=> !inten_r[0])
    else $error("enable clear lost");
  a_irq_level: assert property (s_irq_pending |=> irq_o)
    else $error("irq not raised");
  a_irq_quiet: assert property (!(s_irq_pending) |=> !irq_o)
    else $error("irq without cause");
  a_port_flag: assert property (sense_detect_i |=> port_flag_r ##1 port_flag_r || $past(wr_i))
    else $error("multi-pin flag not set");
  a_port_pub: assert property (sense_detect_i && port_en_r |=> ic_pub_o[$past(port_idx_r)])
    else $error("multi-pin publish lost");

  for (genvar g = 0; g < `PTEV_NCH; g++)
  begin : g_chk
    a_flag_set: assert property (evt_hit[g] |=> flag_r[g])
      else $error("event flag not set");
    a_flag_hold: assert property (flag_r[g] && !flag_wr[g] |=> flag_r[g])
      else $error("event flag dropped");
    a_pub_pulse: assert property (evt_hit[g] && pub_en_r[g] |=> ic_pub_o[$past(pub_idx_r[g])])
      else $error("event publish lost");
    a_clr_wins: assert property (trig_clr[g] |=> !ch_out_r[g])
      else $error("drive-low not applied");
    a_set_drive: assert property (trig_set[g] && !trig_clr[g] |=> ch_out_r[g])
      else $error("drive-high not applied");
    a_pin_owned: assert property (mode_r[g] == PTEV_MODE_TASK |-> pin_oe_o[psel_r[g]])
      else $error("task pin not driven");
  end

endmodule

// ==== tb/ptev_pin_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// pins outside the block
// ----------------------------------------
module ptev_pin_model
(
  input wire logic [31:0] pin_out_i,
  input wire logic [31:0] pin_oe_i,
  input wire logic [31:0] ext_lvl_i,
  output logic [31:0] pin_in_o
);
  // wire level: a driven pin reads back its own level, others follow the outside source
  // the outside source only drives pins nobody else enables, so no contention
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      pin_in_o[i] = pin_oe_i[i] ? pin_out_i[i] : ext_lvl_i[i];
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps

module testbench;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [15:0] ic_evt_i = 16'h0000;
  logic [15:0] ic_pub_o;
  logic [31:0] pin_in_i;
  logic [31:0] gpio_out_i = 32'h00f0_0000; // pin 5 low from ordinary gpio
  logic [31:0] gpio_oe_i = 32'h0f00_020f; // gpio drives pin 9, so event mode must take its enable away
  logic [31:0] pin_out_o;
  logic [31:0] pin_oe_o;
  logic [31:0] ext_lvl = 32'h0000_0000; // outside level of undriven pins
  logic sense_detect_i = 1'b0;
  logic irq_o;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;

  always #20 clk_i = ~clk_i;

  ptev_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ic_evt_i(ic_evt_i), .ic_pub_o(ic_pub_o), .pin_in_i(pin_in_i),
    .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .sense_detect_i(sense_detect_i), .irq_o(irq_o));

  ptev_pin_model pins (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_lvl_i(ext_lvl), .pin_in_o(pin_in_i));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, exp, rdata_o);
  endtask

  task automatic pin_chk(input string what, input int p, input logic oe, input logic lvl);
    @(negedge clk_i);
    chk(what, {30'h0, oe, lvl}, {30'h0, pin_oe_o[p], pin_out_o[p]});
  endtask

  task automatic ic_pulse(input logic [15:0] m);
    @(posedge clk_i);
    ic_evt_i <= m;
    @(posedge clk_i);
    ic_evt_i <= 16'h0000;
  endtask

  // counts cycles a publish bit is high; a pulse must last one cycle only
  task automatic pub_cnt(input string what, input int b, input int exp);
    int n = 0;
    repeat (5)
    begin
      @(negedge clk_i);
      if (ic_pub_o[b] === 1'b1)
        n++;
    end
    chk(what, exp, n);
  endtask

  task automatic drive(input int p, input logic lvl);
    @(posedge clk_i);
    ext_lvl[p] <= lvl;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [11:0] regs [7] = '{12'h304, 12'h308, 12'h510, 12'h100, 12'h0e0, 12'h1fc, 12'h400};
    foreach (regs[i])
      rd_chk("reset word", regs[i], 32'h0000_0000);
    @(negedge clk_i);
    chk("gpio passthrough out", gpio_out_i, pin_out_o);
    chk("gpio passthrough oe", gpio_oe_i, pin_oe_o);
  endtask

  task automatic t_task();
    logic [31:0] cfg [3] = '{32'h0001_0503, 32'h0012_0503, 32'h0010_0503};
    logic ini [3] = '{1'b0, 1'b1, 1'b1};
    logic aft [3] = '{1'b1, 1'b0, 1'b1};
    // channel 1 alone owns pin 5, toggle, start high
    wr(12'h514, 32'h0013_0503);
    pin_chk("task init high", 5, 1'b1, 1'b1);
    wr(12'h064, 32'h0000_0001);
    pin_chk("low trigger", 5, 1'b1, 1'b0);
    wr(12'h034, 32'h0000_0001);
    pin_chk("high trigger", 5, 1'b1, 1'b1);
    wr(12'h004, 32'h0000_0000);
    pin_chk("action write zero", 5, 1'b1, 1'b1);
    wr(12'h004, 32'h0000_0001);
    pin_chk("action toggle", 5, 1'b1, 1'b0);
    // set, clear and none actions, each from its own initial level
    for (int i = 0; i < 3; i++)
    begin
      wr(12'h514, cfg[i]);
      pin_chk("polarity init", 5, 1'b1, ini[i]);
      wr(12'h004, 32'h0000_0001);
      pin_chk("polarity action", 5, 1'b1, aft[i]);
    end
    // released pin goes back to gpio, tasks ignored
    wr(12'h514, 32'h0000_0500);
    wr(12'h034, 32'h0000_0001);
    pin_chk("disabled pin", 5, 1'b0, 1'b0);
  endtask

  task automatic t_sub();
    wr(12'h514, 32'h0003_0503);
    wr(12'h0b4, 32'h8000_0004);
    rd_chk("high subscription", 12'h0b4, 32'h8000_0004);
    wr(12'h0e4, 32'h0000_0006);
    ic_pulse(16'h0010);
    pin_chk("subscribed high", 5, 1'b1, 1'b1);
    ic_pulse(16'h0040);
    pin_chk("disabled subscription", 5, 1'b1, 1'b1);
    // both tasks on one channel: low must win
    wr(12'h0e4, 32'h8000_0004);
    ic_pulse(16'h0010);
    pin_chk("low over high", 5, 1'b1, 1'b0);
    wr(12'h0e4, 32'h0000_0000);
    wr(12'h084, 32'h8000_0009);
    ic_pulse(16'h0200);
    pin_chk("subscribed action", 5, 1'b1, 1'b1);
    wr(12'h514, 32'h0000_0000);
  endtask

  task automatic t_event();
    wr(12'h518, 32'h0001_0901);
    wr(12'h188, 32'h8000_0007);
    wr(12'h304, 32'h0000_0004);
    rd_chk("enable via off word", 12'h308, 32'h0000_0004);
    @(negedge clk_i);
    chk("event pin input", 32'h0, {31'h0, pin_oe_o[9]});
    drive(9, 1'b1);
    pub_cnt("rise publish", 7, 1);
    chk("irq on", 32'h1, {31'h0, irq_o});
    rd_chk("flag sticky", 12'h108, 32'h0000_0001);
    drive(9, 1'b0);
    pub_cnt("fall ignored", 7, 0);
    wr(12'h108, 32'h0000_0000);
    rd_chk("flag cleared", 12'h108, 32'h0000_0000);
    @(negedge clk_i);
    chk("irq off", 32'h0, {31'h0, irq_o});
    wr(12'h518, 32'h0003_0901);
    drive(9, 1'b1);
    pub_cnt("any rise", 7, 1);
    drive(9, 1'b0);
    pub_cnt("any fall", 7, 1);
    wr(12'h518, 32'h0002_0901);
    drive(9, 1'b1);
    pub_cnt("fall pol rise", 7, 0);
    drive(9, 1'b0);
    pub_cnt("fall pol fall", 7, 1);
    wr(12'h308, 32'h0000_0004);
    rd_chk("enable cleared", 12'h304, 32'h0000_0000);
    @(negedge clk_i);
    chk("masked irq", 32'h0, {31'h0, irq_o});
    wr(12'h108, 32'h0000_0000);
  endtask

  task automatic t_port();
    wr(12'h1fc, 32'h8000_0002);
    wr(12'h304, 32'h0000_0100);
    wr(12'h304, 32'h0000_0000);
    rd_chk("zero keeps enable", 12'h304, 32'h0000_0100);
    @(posedge clk_i);
    sense_detect_i <= 1'b1;
    @(posedge clk_i);
    sense_detect_i <= 1'b0;
    pub_cnt("multi publish", 2, 1);
    rd_chk("multi flag", 12'h17c, 32'h0000_0001);
    chk("multi irq", 32'h1, {31'h0, irq_o});
    wr(12'h308, 32'h0000_0100);
    wr(12'h17c, 32'h0000_0000);
    rd_chk("multi flag cleared", 12'h17c, 32'h0000_0000);
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_task();
    t_sub();
    t_event();
    t_port();
    end_sim();
  end

  // hang guard, far above the fewer than 200 cycles the run needs
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      end_sim();
    end
  end
endmodule
